/* File: hdl/fdl_link.sv */
`timescale 1ns/1ps
module fdl_link (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic link_bit_valid_i,
  input wire logic link_bit_i,
  input wire fdl_pkg::fdl_slot_pos_s rx_pos_i,
  input wire fdl_pkg::fdl_slot_pos_s tx_pos_i,
  output logic rx_hdlc_use_o,
  output logic tx_hdlc_use_o,
  output logic irq_n_o
);

  fdl_pkg::fdl_state_s state_reg;
  fdl_pkg::fdl_state_s state_next;
  logic d_valid;
  logic d_bit;
  logic rx_sel;
  logic tx_sel;
  logic byte_done;
  logic [7:0] new_byte;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic wr_en;
  logic rd_setup;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic rd_hit;

  // --------------------------------------------------------------
  // receive stream and slot routing
  // --------------------------------------------------------------
  fdl_destuff u_destuff (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(state_reg.destuff_en),
    .bit_valid_i(link_bit_valid_i),
    .bit_i(link_bit_i),
    .out_valid_o(d_valid),
    .out_bit_o(d_bit)
  );

  fdl_slot_sel u_rx_sel (
    .ctrl_i(state_reg.rx_ctrl),
    .mask_i(state_reg.rx_mask),
    .pos_i(rx_pos_i),
    .use_o(rx_sel)
  );

  fdl_slot_sel u_tx_sel (
    .ctrl_i(state_reg.tx_ctrl),
    .mask_i(state_reg.tx_mask),
    .pos_i(tx_pos_i),
    .use_o(tx_sel)
  );

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = a == {2'b00, idx, 2'b00};
  endfunction : hit

  always_comb begin
    wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];
    rd_setup = psel_i & ~penable_i & ~pwrite_i;
    wbyte = pwdata_i[7:0];
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (hit(paddr_i, fdl_pkg::IDX_LINK_BYTE)) begin
      rd_val = state_reg.link_byte;
    end else if (hit(paddr_i, fdl_pkg::IDX_MATCH_A)) begin
      rd_val = state_reg.match_a;
    end else if (hit(paddr_i, fdl_pkg::IDX_MATCH_B)) begin
      rd_val = state_reg.match_b;
    end else if (hit(paddr_i, fdl_pkg::IDX_CONFIG)) begin
      rd_val = {7'h00, state_reg.destuff_en};
    end else if (hit(paddr_i, fdl_pkg::IDX_STATUS)) begin
      rd_val = state_reg.status;
    end else if (hit(paddr_i, fdl_pkg::IDX_IRQ_EN)) begin
      rd_val = state_reg.irq_en;
    end else if (hit(paddr_i, fdl_pkg::IDX_IRQ_CLR)) begin
      rd_val = 8'h00;
    end else if (hit(paddr_i, fdl_pkg::IDX_RX_CTRL)) begin
      rd_val = state_reg.rx_ctrl;
    end else if (hit(paddr_i, fdl_pkg::IDX_RX_MASK)) begin
      rd_val = state_reg.rx_mask;
    end else if (hit(paddr_i, fdl_pkg::IDX_TX_CTRL)) begin
      rd_val = state_reg.tx_ctrl;
    end else if (hit(paddr_i, fdl_pkg::IDX_TX_MASK)) begin
      rd_val = state_reg.tx_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    byte_done = d_valid & (state_reg.cnt == fdl_pkg::LAST_BIT_CNT);
    new_byte = {d_bit, state_reg.shift[7:1]};
    set_bits = 8'h00;
    clr_bits = 8'h00;
    if (d_valid) begin
      state_next.shift = new_byte;
      state_next.cnt = state_reg.cnt + 3'h1;
    end
    if (byte_done) begin
      state_next.link_byte = new_byte;
      set_bits[fdl_pkg::ST_FULL_BIT] = 1'b1;
      if (new_byte == state_reg.match_a ||
          new_byte == state_reg.match_b) begin
        set_bits[fdl_pkg::ST_MATCH_BIT] = 1'b1;
      end
    end
    if (wr_en) begin
      if (hit(paddr_i, fdl_pkg::IDX_MATCH_A)) begin
        state_next.match_a = wbyte;
      end
      if (hit(paddr_i, fdl_pkg::IDX_MATCH_B)) begin
        state_next.match_b = wbyte;
      end
      if (hit(paddr_i, fdl_pkg::IDX_CONFIG)) begin
        state_next.destuff_en = wbyte[fdl_pkg::CFG_DESTUFF_BIT];
      end
      if (hit(paddr_i, fdl_pkg::IDX_IRQ_EN)) begin
        state_next.irq_en = wbyte & fdl_pkg::STATUS_USED;
      end
      if (hit(paddr_i, fdl_pkg::IDX_IRQ_CLR)) begin
        clr_bits = wbyte;
      end
      if (hit(paddr_i, fdl_pkg::IDX_RX_CTRL)) begin
        state_next.rx_ctrl = wbyte & fdl_pkg::CTRL_RW_MASK;
      end
      if (hit(paddr_i, fdl_pkg::IDX_RX_MASK)) begin
        state_next.rx_mask = wbyte;
      end
      if (hit(paddr_i, fdl_pkg::IDX_TX_CTRL)) begin
        state_next.tx_ctrl = wbyte & fdl_pkg::CTRL_RW_MASK;
      end
      if (hit(paddr_i, fdl_pkg::IDX_TX_MASK)) begin
        state_next.tx_mask = wbyte;
      end
    end
    // set wins over clear
    state_next.status = ((state_reg.status & ~clr_bits) | set_bits) &
      fdl_pkg::STATUS_USED;
    if (rd_setup) begin
      state_next.prdata = {24'h00_0000, rd_val};
    end
    if (psel_i & ~penable_i) begin
      state_next.pslverr = ~rd_hit;
    end
    state_next.rx_use = rx_sel;
    state_next.tx_use = tx_sel;
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign prdata_o = state_reg.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & state_reg.pslverr;
  assign rx_hdlc_use_o = state_reg.rx_use;
  assign tx_hdlc_use_o = state_reg.tx_use;
  assign irq_n_o = ~|(state_reg.status & state_reg.irq_en);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  full_flag_set_a: assert property (
    byte_done |=> state_reg.status[4] &&
    state_reg.link_byte == $past(new_byte))
    else $error("full flag or byte missing after eighth bit");

  match_flag_set_a: assert property (
    byte_done && (new_byte == state_reg.match_a) |=> state_reg.status[2])
    else $error("match flag not set");

  irq_low_enabled_a: assert property (
    $rose(state_reg.status[4]) && state_reg.irq_en[4] |-> !irq_n_o)
    else $error("interrupt not low for enabled full");

  lsb_first_a: assert property (
    byte_done |=> state_reg.link_byte[0] == $past(state_reg.shift[1]) &&
    state_reg.link_byte[7] == $past(d_bit))
    else $error("first bit not in lsb");

  byte_stable_a: assert property (
    !byte_done |=> $stable(state_reg.link_byte))
    else $error("link byte changed between fills");

  set_wins_a: assert property (
    byte_done && wr_en && hit(paddr_i, fdl_pkg::IDX_IRQ_CLR)
    |=> state_reg.status[4])
    else $error("clear beat a new full event");

  tx_fdl_route_a: assert property (
    !state_reg.tx_ctrl[7] && tx_pos_i.fdl_time |=> tx_hdlc_use_o)
    else $error("transmit controller not on link");

  tx_suppress_a: assert property (
    state_reg.tx_ctrl[7] && state_reg.tx_mask[tx_pos_i.bit_pos]
    |=> !tx_hdlc_use_o)
    else $error("suppressed transmit bit used");

  rx_single_slot_a: assert property (
    state_reg.rx_ctrl[7] && !state_reg.rx_ctrl[5] && rx_pos_i.ds0_time &&
    rx_pos_i.slot != state_reg.rx_ctrl[4:0] |=> !rx_hdlc_use_o)
    else $error("receive controller used wrong slot");

  tx_bit6_zero_a: assert property (
    !state_reg.tx_ctrl[6])
    else $error("unassigned transmit bit stored");

  match_b_flag_a: assert property (
    byte_done && (new_byte == state_reg.match_b) |=> state_reg.status[2])
    else $error("second match byte not flagged");

  irq_low_match_a: assert property (
    state_reg.status[2] && state_reg.irq_en[2] |-> !irq_n_o)
    else $error("interrupt not low for enabled match");

  clear_full_a: assert property (
    !byte_done && wr_en && hit(paddr_i, fdl_pkg::IDX_IRQ_CLR) &&
    pwdata_i[4] |=> !state_reg.status[4])
    else $error("full flag not cleared");

  rx_suppress_a: assert property (
    state_reg.rx_ctrl[7] && state_reg.rx_mask[rx_pos_i.bit_pos]
    |=> !rx_hdlc_use_o)
    else $error("suppressed receive bit used");

  tx_block_a: assert property (
    state_reg.tx_ctrl[7] && state_reg.tx_ctrl[5] && tx_pos_i.ds0_time &&
    !tx_pos_i.in_block |=> !tx_hdlc_use_o)
    else $error("transmit slot outside block used");

  rx_fdl_route_a: assert property (
    !state_reg.rx_ctrl[7] && !rx_pos_i.fdl_time |=> !rx_hdlc_use_o)
    else $error("receive controller used off the link");

  tx_chan_hit_a: assert property (
    state_reg.tx_ctrl[7] && !state_reg.tx_ctrl[5] && tx_pos_i.ds0_time &&
    tx_pos_i.slot == state_reg.tx_ctrl[4:0] &&
    !state_reg.tx_mask[tx_pos_i.bit_pos] |=> tx_hdlc_use_o)
    else $error("selected transmit slot not used");

  byte_full_c: cover property (byte_done);
  match_seen_c: cover property (byte_done ##1 state_reg.status[2]);
  tx_block_c: cover property (state_reg.tx_ctrl[5] && tx_hdlc_use_o);
  irq_assert_c: cover property ($fell(irq_n_o));

endmodule : fdl_link

/* File: hdl/fdl_pkg.sv */
package fdl_pkg;

  // --------------------------------------------------------------
  // register indices (byte address is four times the index)
  // --------------------------------------------------------------
  localparam logic [7:0] IDX_LINK_BYTE = 8'h28;
  localparam logic [7:0] IDX_MATCH_A = 8'h29;
  localparam logic [7:0] IDX_MATCH_B = 8'h2A;
  localparam logic [7:0] IDX_CONFIG = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam logic [7:0] IDX_IRQ_EN = 8'h32;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h33;
  localparam logic [7:0] IDX_RX_CTRL = 8'h90;
  localparam logic [7:0] IDX_RX_MASK = 8'h91;
  localparam logic [7:0] IDX_TX_CTRL = 8'h92;
  localparam logic [7:0] IDX_TX_MASK = 8'h93;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_CHAN_MSB = 4;
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CFG_DESTUFF_BIT = 0;
  localparam int ST_FULL_BIT = 4;
  localparam int ST_MATCH_BIT = 2;
  localparam logic [7:0] STATUS_USED = 8'h14;
  localparam logic [7:0] CTRL_RW_MASK = 8'hBF;

  // --------------------------------------------------------------
  // reset values and counts
  // --------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT_CNT = 3'h7;
  localparam logic [2:0] MAX_ONES = 3'h6;
  localparam logic [2:0] STUFF_ONES = 3'h5;

  // --------------------------------------------------------------
  // line timing of one direction
  // --------------------------------------------------------------
  typedef struct packed {
    logic fdl_time;
    logic ds0_time;
    logic [4:0] slot;
    logic [2:0] bit_pos;
    logic in_block;
  } fdl_slot_pos_s;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [7:0] link_byte;
    logic [7:0] match_a;
    logic [7:0] match_b;
    logic [7:0] rx_ctrl;
    logic [7:0] rx_mask;
    logic [7:0] tx_ctrl;
    logic [7:0] tx_mask;
    logic destuff_en;
    logic [7:0] status;
    logic [7:0] irq_en;
    logic [31:0] prdata;
    logic pslverr;
    logic rx_use;
    logic tx_use;
  } fdl_state_s;

endpackage : fdl_pkg

/* File: hdl/fdl_slot_sel.sv */
`timescale 1ns/1ps
module fdl_slot_sel (
  input wire logic [7:0] ctrl_i,
  input wire logic [7:0] mask_i,
  input wire fdl_pkg::fdl_slot_pos_s pos_i,
  output logic use_o
);

  logic slot_hit;

  always_comb begin
    slot_hit = 1'b0;
    use_o = 1'b0;
    if (!ctrl_i[fdl_pkg::CTRL_ENABLE_BIT]) begin
      // controller on the data link
      use_o = pos_i.fdl_time;
    end else begin
      if (ctrl_i[fdl_pkg::CTRL_MODE_BIT]) begin
        slot_hit = pos_i.in_block;
      end else begin
        slot_hit = pos_i.slot ==
          ctrl_i[fdl_pkg::CTRL_CHAN_MSB:fdl_pkg::CTRL_CHAN_LSB];
      end
      // mask bit 7 is DS0 bit 8, bit 0 is DS0 bit 1
      use_o = pos_i.ds0_time & slot_hit & ~mask_i[pos_i.bit_pos];
    end
  end

endmodule : fdl_slot_sel

/* File: hdl/fdl_destuff.sv */
`timescale 1ns/1ps
module fdl_destuff (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  output logic out_valid_o,
  output logic out_bit_o
);

  logic [2:0] ones_reg;
  logic [2:0] ones_next;
  logic drop;

  always_comb begin
    drop = enable_i & bit_valid_i & ~bit_i &
      (ones_reg == fdl_pkg::STUFF_ONES);
    out_valid_o = bit_valid_i & ~drop;
    out_bit_o = bit_i;
    ones_next = ones_reg;
    if (bit_valid_i) begin
      if (!bit_i) begin
        ones_next = 3'h0;
      end else if (ones_reg != fdl_pkg::MAX_ONES) begin
        ones_next = ones_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ones_reg <= 3'h0;
    end else begin
      ones_reg <= ones_next;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  drop_after_five_a: assert property (
    enable_i && bit_valid_i && !bit_i && ones_reg == 3'h5 |-> !out_valid_o)
    else $error("stuffed zero not removed");

  keep_after_six_a: assert property (
    bit_valid_i && !bit_i && ones_reg == 3'h6 |-> out_valid_o)
    else $error("zero after six ones removed");

  destuff_drop_c: cover property (drop);

endmodule : fdl_destuff

/* File: tb/fdl_line_model.sv */
`timescale 1ns/1ps
module fdl_line_model (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic send_i,
  input wire logic [15:0] bits_i,
  input wire logic [4:0] nbits_i,
  output logic valid_o,
  output logic bit_o,
  output logic busy_o
);
  logic [15:0] sh_reg;
  logic [4:0] left_reg;
  logic gap_reg;
  // ----------------------------------------
  // recovered link bit source
  // ----------------------------------------
  // one strobe per bit, bit 0 first
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sh_reg <= 16'h0000;
      left_reg <= 5'h00;
      gap_reg <= 1'b0;
      valid_o <= 1'b0;
      bit_o <= 1'b0;
    end else if (send_i) begin
      sh_reg <= bits_i;
      left_reg <= nbits_i;
      gap_reg <= 1'b0;
      valid_o <= 1'b0;
    end else if (left_reg != 5'h00 && !gap_reg) begin
      valid_o <= 1'b1;
      bit_o <= sh_reg[0];
      sh_reg <= sh_reg >> 1;
      left_reg <= left_reg - 5'h01;
      gap_reg <= 1'b1;
    end else begin
      // data line carries no meaning between strobes
      valid_o <= 1'b0;
      bit_o <= ~bit_o;
      gap_reg <= 1'b0;
    end
  end
  assign busy_o = (left_reg != 5'h00) || valid_o;
endmodule : fdl_line_model

/* File: tb/fdl_ds0_select_legacy_rx_bench.sv */
`timescale 1ns/1ps
module fdl_ds0_select_legacy_rx_bench;
  logic ref_clk_i, sys_rst_i, psel, pen, pwr, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic lv, lb, rx_use, tx_use, irq_n, send, busy;
  logic [15:0] sbits;
  logic [4:0] snb;
  fdl_pkg::fdl_slot_pos_s rx_pos, tx_pos;
  int err_total, cmp_count;

  fdl_link u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link_bit_valid_i(lv),
    .link_bit_i(lb), .rx_pos_i(rx_pos), .tx_pos_i(tx_pos),
    .rx_hdlc_use_o(rx_use), .tx_hdlc_use_o(tx_use), .irq_n_o(irq_n));
  fdl_line_model u_line (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .send_i(send), .bits_i(sbits), .nbits_i(snb), .valid_o(lv),
    .bit_o(lb), .busy_o(busy));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= 32'(wd);
    @(posedge ref_clk_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    cmp(rd, 32'(exp));
  endtask : rchk

  task automatic link_send(input logic [15:0] b, input logic [4:0] nb);
    int n;
    @(posedge ref_clk_i);
    send <= 1'b1;
    sbits <= b;
    snb <= nb;
    @(posedge ref_clk_i);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (busy !== 1'b0 && n < 100);
    if (busy !== 1'b0) begin
      err_total++;
      final_report();
    end
  endtask : link_send

  task automatic slot(input logic [7:0] ctl, input logic [7:0] msk,
                      input logic [10:0] p, input logic ex);
    wr(fdl_pkg::IDX_RX_CTRL, ctl);
    wr(fdl_pkg::IDX_TX_CTRL, ctl);
    wr(fdl_pkg::IDX_RX_MASK, msk);
    wr(fdl_pkg::IDX_TX_MASK, msk);
    @(posedge ref_clk_i);
    rx_pos <= fdl_pkg::fdl_slot_pos_s'(p);
    tx_pos <= fdl_pkg::fdl_slot_pos_s'(p);
    @(posedge ref_clk_i);
    rx_pos <= '0;
    tx_pos <= '0;
    #1;
    cmp(32'(rx_use), 32'(ex));
    cmp(32'(tx_use), 32'(ex));
  endtask : slot

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, send} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h1;
    sbits = 16'h0000;
    snb = 5'h00;
    rx_pos = '0;
    tx_pos = '0;
    err_total = 0;
    cmp_count = 0;
    sys_rst_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'h00);
    rchk(fdl_pkg::IDX_STATUS, 8'h00);
    cmp(32'(irq_n), 32'h0000_0001);
    wr(fdl_pkg::IDX_TX_CTRL, 8'h9f);
    rchk(fdl_pkg::IDX_TX_CTRL, 8'h9f);
    wr(fdl_pkg::IDX_TX_MASK, 8'h5a);
    pstrb <= 4'h0;
    wr(fdl_pkg::IDX_TX_MASK, 8'hff);
    pstrb <= 4'h1;
    rchk(fdl_pkg::IDX_TX_MASK, 8'h5a);
    wr(fdl_pkg::IDX_LINK_BYTE, 8'hff);
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'h00);
    rchk(fdl_pkg::IDX_IRQ_CLR, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    cmp(32'(er), 32'h0000_0001);
    $display("test registers done");
    slot(8'h00, 8'h00, {2'b10, 5'h00, 3'h0, 1'b0}, 1'b1);
    slot(8'h00, 8'h00, {2'b01, 5'h05, 3'h3, 1'b0}, 1'b0);
    slot(8'h85, 8'h00, {2'b01, 5'h05, 3'h3, 1'b0}, 1'b1);
    slot(8'h85, 8'h00, {2'b01, 5'h06, 3'h3, 1'b0}, 1'b0);
    slot(8'h85, 8'h00, {2'b10, 5'h05, 3'h3, 1'b0}, 1'b0);
    slot(8'h9f, 8'h00, {2'b01, 5'h1f, 3'h0, 1'b0}, 1'b1);
    slot(8'h85, 8'h08, {2'b01, 5'h05, 3'h3, 1'b0}, 1'b0);
    slot(8'h85, 8'h80, {2'b01, 5'h05, 3'h7, 1'b0}, 1'b0);
    slot(8'h85, 8'h80, {2'b01, 5'h05, 3'h0, 1'b0}, 1'b1);
    slot(8'ha0, 8'h00, {2'b01, 5'h09, 3'h2, 1'b1}, 1'b1);
    slot(8'ha0, 8'h00, {2'b01, 5'h09, 3'h2, 1'b0}, 1'b0);
    $display("test slot select done");
    wr(fdl_pkg::IDX_MATCH_A, 8'h5a);
    wr(fdl_pkg::IDX_MATCH_B, 8'h66);
    wr(fdl_pkg::IDX_IRQ_EN, 8'h10);
    link_send(16'h003c, 5'h08);
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'h3c);
    rchk(fdl_pkg::IDX_STATUS, 8'h10);
    cmp(32'(irq_n), 32'h0000_0000);
    wr(fdl_pkg::IDX_IRQ_CLR, 8'h10);
    rchk(fdl_pkg::IDX_STATUS, 8'h00);
    cmp(32'(irq_n), 32'h0000_0001);
    wr(fdl_pkg::IDX_IRQ_EN, 8'h04);
    link_send(16'h005a, 5'h08);
    rchk(fdl_pkg::IDX_STATUS, 8'h14);
    wr(fdl_pkg::IDX_IRQ_CLR, 8'h10);
    rchk(fdl_pkg::IDX_STATUS, 8'h04);
    cmp(32'(irq_n), 32'h0000_0000);
    wr(fdl_pkg::IDX_IRQ_CLR, 8'h04);
    rchk(fdl_pkg::IDX_STATUS, 8'h00);
    cmp(32'(irq_n), 32'h0000_0001);
    wr(fdl_pkg::IDX_IRQ_EN, 8'h00);
    link_send(16'h0066, 5'h08);
    rchk(fdl_pkg::IDX_STATUS, 8'h14);
    cmp(32'(irq_n), 32'h0000_0001);
    wr(fdl_pkg::IDX_IRQ_CLR, 8'h14);
    $display("test receive and interrupt done");
    wr(fdl_pkg::IDX_CONFIG, 8'h01);
    link_send(16'h019f, 5'h09);
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'hdf);
    link_send(16'h00bf, 5'h08);
    link_send(16'h00f0, 5'h08);
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'hf0);
    link_send(16'h00bf, 5'h08);
    rchk(fdl_pkg::IDX_LINK_BYTE, 8'hbf);
    $display("test destuffer done");
    final_report();
  end
endmodule : fdl_ds0_select_legacy_rx_bench
